/* rtl/usbrx_ctrl.sv */
// Purpose: receive-side fields of eight usb endpoint registers, apb slave, irq
// Assumes: link logic and bus reset come from the pclk domain
// Notes: transmit fields and endpoint address bits read as zero here

`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - rx done flag set when out or setup to this endpoint completes cleanly
// - with done irq enable and the endpoint's mask bit set, each rx done setting raises the interrupt
// - writing 0 clears rx done, writing 1 keeps it, always readable
// - non-iso endpoints: rx toggle gives expected data pid, 0 data0, 1 data1
// - writing 1 to rx toggle inverts it, writing 0 leaves it
// - control endpoint: setup received clears rx toggle
// - iso endpoint: rx toggle inverts right after each received packet
// - iso: toggle picks buffer; double-buffered: toggle drives flow control
// - good out or setup moves handshake to nak; write 1 inverts each bit
// - handshake codes: 00 disabled, 01 stall, 10 nak
// - double-buffered bulk: handshake goes to nak if next buffer is busy, else holds
// - iso endpoint: handshake unchanged on successful transaction
// - setup flag set when a setup token is received correctly
// - setup flag is read only, writes ignored
// - setup flag only meaningful on control endpoints
// - type 00 bulk, 01 control, 10 iso, 11 interrupt; kind on bulk doubles buffer
// - bus or forced reset clears all endpoint bits except done flags
module usbrx_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usbrx_pkg::usbrx_evt_t rx_evt,
  input wire logic bus_reset,
  input wire logic next_buf_busy,
  output usbrx_pkg::usbrx_ep_t [usbrx_pkg::NUM_EP-1:0] ep_view,
  output logic irq
);
  import usbrx_pkg::*;

  // endpoint state, one entry per endpoint
  logic [NUM_EP-1:0] done_q;
  logic [NUM_EP-1:0] tog_q;
  logic [NUM_EP-1:0][1:0] hs_q;
  logic [NUM_EP-1:0] setup_q;
  logic [NUM_EP-1:0][1:0] type_q;
  logic [NUM_EP-1:0] kind_q;

  // module control, interrupt status and mask
  logic [31:0] ctrl_q;
  logic [NUM_EP-1:0] istat_q;
  logic [NUM_EP-1:0] imask_q;
  logic [31:0] rdata_q;
  logic err_q;

  logic wr_acc;
  logic setup_ph;
  logic soft_rst;
  logic [NUM_EP-1:0] ep_wr;
  logic [NUM_EP-1:0] ep_hit;

  // true when the address selects endpoint register n
  function automatic logic is_ep(input logic [7:0] a, input int unsigned n);
    logic [7:0] base;
    base = ADDR_EP0 + 8'(n * 4);
    return (a == base);
  endfunction : is_ep

  // true for any address the slave decodes
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = (a >= ADDR_EP0) && (a <= ADDR_EP7) && (a[1:0] == 2'h0);
    return hit || (a == ADDR_CTRL) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // apb handshake: every access finishes in its first access cycle
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = psel && penable;
  assign prdata = rdata_q;
  assign pslverr = psel && penable && err_q;

  // forced reset is held while the control bit stays set
  assign soft_rst = bus_reset || ctrl_q[BIT_FORCED_MODULE_RESET];

  ////////////////////////////////////////////////////////////////////////////////
  // per-endpoint logic
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      logic tog_d;
      logic [1:0] hs_d;
      logic dbl_bulk;

      assign ep_wr[g] = wr_acc && is_ep(paddr, g);
      assign ep_hit[g] = rx_evt.done && (rx_evt.ep == 3'(g));
      assign dbl_bulk = (type_q[g] == TYPE_BULK) && kind_q[g];

      // done flag survives soft resets; a set beats a clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_q[g] <= 1'b0;
        end else if (ep_hit[g]) begin
          done_q[g] <= 1'b1;
        end else if (ep_wr[g] && !pwdata[BIT_RX_DONE]) begin
          done_q[g] <= 1'b0;
        end
      end

      // hardware update first, software toggle applied on top of it
      always_comb begin
        tog_d = tog_q[g];
        hs_d = hs_q[g];
        if (ep_hit[g]) begin
          if (type_q[g] == TYPE_ISO) begin
            tog_d = ~tog_q[g];
          end else if ((type_q[g] == TYPE_CTRL) && rx_evt.setup) begin
            tog_d = 1'b0;
          end else begin
            tog_d = ~tog_q[g];
          end
          if (type_q[g] == TYPE_ISO) begin
            hs_d = hs_q[g];
          end else if (dbl_bulk) begin
            hs_d = next_buf_busy ? HS_NAK : hs_q[g];
          end else begin
            hs_d = HS_NAK;
          end
        end
        if (ep_wr[g]) begin
          tog_d = tog_d ^ pwdata[BIT_RX_TOG];
          hs_d = hs_d ^ pwdata[BIT_HS_HI:BIT_HS_LO];
        end
      end

      // toggle, handshake state and setup flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tog_q[g] <= 1'b0;
          hs_q[g] <= HS_DISABLED;
          setup_q[g] <= 1'b0;
        end else if (soft_rst) begin
          tog_q[g] <= 1'b0;
          hs_q[g] <= HS_DISABLED;
          setup_q[g] <= 1'b0;
        end else begin
          tog_q[g] <= tog_d;
          hs_q[g] <= hs_d;
          if (ep_hit[g]) begin
            setup_q[g] <= rx_evt.setup;
          end
        end
      end

      // type and kind are plain read/write; setup flag takes no write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          type_q[g] <= TYPE_BULK;
          kind_q[g] <= 1'b0;
        end else if (soft_rst) begin
          type_q[g] <= TYPE_BULK;
          kind_q[g] <= 1'b0;
        end else if (ep_wr[g]) begin
          type_q[g] <= pwdata[BIT_TYPE_HI:BIT_TYPE_LO];
          kind_q[g] <= pwdata[BIT_KIND];
        end
      end

      // view for the link logic; on iso the toggle is the buffer select
      assign ep_view[g].toggle = tog_q[g];
      assign ep_view[g].hs = hs_q[g];
      assign ep_view[g].etype = type_q[g];
      assign ep_view[g].kind = kind_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // control register; upper bits are stored as written, software keeps them zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_acc && (paddr == ADDR_CTRL)) begin
      ctrl_q <= pwdata;
    end
  end

  // sticky per-endpoint done events, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
    end else if (wr_acc && (paddr == ADDR_IRQ_STAT)) begin
      istat_q <= (istat_q & ~pwdata[NUM_EP-1:0]) | ep_hit;
    end else begin
      istat_q <= istat_q | ep_hit;
    end
  end

  // mask register, same layout as the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= '0;
    end else if (wr_acc && (paddr == ADDR_IRQ_MASK)) begin
      imask_q <= pwdata[NUM_EP-1:0];
    end
  end

  // level interrupt, also gated by the module-wide done enable
  assign irq = ctrl_q[BIT_DONE_IE] && |(istat_q & imask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // read data captured in the setup cycle so prdata comes from a flop;
  // the trade-off is that it shows state one cycle before the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup_ph) begin
      err_q <= !is_mapped(paddr);
      rdata_q <= '0;
      for (int unsigned n = 0; n < NUM_EP; n++) begin
        if (is_ep(paddr, n)) begin
          rdata_q <= {16'h0000, done_q[n], tog_q[n], hs_q[n], setup_q[n],
                      type_q[n], kind_q[n], 8'h00};
        end
      end
      if (paddr == ADDR_CTRL) begin
        rdata_q <= ctrl_q;
      end
      if (paddr == ADDR_IRQ_STAT) begin
        rdata_q <= {24'h000000, istat_q};
      end
      if (paddr == ADDR_IRQ_MASK) begin
        rdata_q <= {24'h000000, imask_q};
      end
    end
  end

endmodule : usbrx_ctrl

`default_nettype wire

/* inc/usbrx_pkg.sv */
// Purpose: constants and carrier types for the endpoint receive control block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: endpoint registers sit at 0x00..0x1C, one word each

package usbrx_pkg;

  localparam int unsigned NUM_EP = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_EP0 = 8'h00;
  localparam logic [7:0] ADDR_EP7 = 8'h1C;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h64;

  // endpoint register field positions
  localparam int unsigned BIT_RX_DONE = 15;
  localparam int unsigned BIT_RX_TOG = 14;
  localparam int unsigned BIT_HS_HI = 13;
  localparam int unsigned BIT_HS_LO = 12;
  localparam int unsigned BIT_SETUP = 11;
  localparam int unsigned BIT_TYPE_HI = 10;
  localparam int unsigned BIT_TYPE_LO = 9;
  localparam int unsigned BIT_KIND = 8;

  // control register fields and reset value
  localparam int unsigned BIT_DONE_IE = 15;
  localparam int unsigned BIT_FORCED_MODULE_RESET = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] EP_RESET = 32'h0000_0000;

  // receive handshake state codes
  localparam logic [1:0] HS_DISABLED = 2'h0;
  localparam logic [1:0] HS_STALL = 2'h1;
  localparam logic [1:0] HS_NAK = 2'h2;
  localparam logic [1:0] HS_VALID = 2'h3;

  // endpoint type codes
  localparam logic [1:0] TYPE_BULK = 2'h0;
  localparam logic [1:0] TYPE_CTRL = 2'h1;
  localparam logic [1:0] TYPE_ISO = 2'h2;
  localparam logic [1:0] TYPE_INTR = 2'h3;

  // one completed receive transaction from the link logic
  typedef struct packed {
    logic done;
    logic setup;
    logic [2:0] ep;
  } usbrx_evt_t;

  // per-endpoint receive view handed to the link logic
  typedef struct packed {
    logic toggle;
    logic [1:0] hs;
    logic [1:0] etype;
    logic kind;
  } usbrx_ep_t;

endpackage : usbrx_pkg

/* verification/usbrx_chk.sv */
// Purpose: port checks of the endpoint receive control block
// Assumes: one pclk domain, presetn async active low
// Notes: ctrl and mask writes are mirrored so fields are judged only while free to move
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module usbrx_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire usbrx_pkg::usbrx_evt_t rx_evt,
  input wire logic bus_reset,
  input wire logic next_buf_busy,
  input wire usbrx_pkg::usbrx_ep_t [usbrx_pkg::NUM_EP-1:0] ep_view,
  input wire logic irq
);
  import usbrx_pkg::*;
  logic wr, epw, ok, forced_module_reset_q, ie_q;
  logic [7:0] mask_q;
  logic [2:0] ep_q, pa_q;
  usbrx_ep_t v, w;
  // v: endpoint of the event, w: endpoint being written
  assign wr = psel & penable & pwrite;
  assign epw = wr & (paddr <= ADDR_EP7) & (paddr[1:0] == 2'h0);
  assign ok = ~wr & ~bus_reset & ~forced_module_reset_q;
  assign v = ep_view[rx_evt.ep];
  assign w = ep_view[paddr[4:2]];
  // forced reset holds the fields cleared, so the receive and write checks pause while it is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_module_reset_q <= CTRL_RESET[BIT_FORCED_MODULE_RESET];
      ie_q <= CTRL_RESET[BIT_DONE_IE];
      mask_q <= 8'h00;
    end else if (wr && paddr == ADDR_CTRL) begin
      forced_module_reset_q <= pwdata[BIT_FORCED_MODULE_RESET];
      ie_q <= pwdata[BIT_DONE_IE];
    end else if (wr && paddr == ADDR_IRQ_MASK) begin
      mask_q <= pwdata[7:0];
    end
  end
  // which endpoint the previous cycle touched
  always_ff @(posedge pclk) begin
    ep_q <= rx_evt.ep;
    pa_q <= paddr[4:2];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rx_nak_a: assert property (rx_evt.done && ok && v.etype[0] |=> ep_view[ep_q].hs == HS_NAK)
    else $error("handshake not nak");
  setup_clr_a: assert property (rx_evt.done && rx_evt.setup && ok && v.etype == TYPE_CTRL |=> !ep_view[ep_q].toggle)
    else $error("setup kept toggle");
  iso_rx_a: assert property (rx_evt.done && ok && v.etype == TYPE_ISO |=>
    ep_view[ep_q].toggle != $past(v.toggle) && ep_view[ep_q].hs == $past(v.hs)) else $error("iso receive wrong");
  dbl_keep_a: assert property (rx_evt.done && ok && v.etype == TYPE_BULK && v.kind && !next_buf_busy
    |=> ep_view[ep_q].hs == $past(v.hs)) else $error("double buffer state moved");
  bus_clr_a: assert property (bus_reset && !wr && !rx_evt.done |=> ep_view == '0)
    else $error("bus reset left fields");
  type_wr_a: assert property (epw && !bus_reset && !forced_module_reset_q |=>
    {ep_view[pa_q].etype, ep_view[pa_q].kind} == $past(pwdata[10:8])) else $error("type not written");
  tog_wr_a: assert property (epw && !rx_evt.done && !bus_reset && !forced_module_reset_q |=>
    {ep_view[pa_q].toggle, ep_view[pa_q].hs} == $past({w.toggle, w.hs} ^ pwdata[14:12])) else $error("w1 invert");
  irq_rise_a: assert property (rx_evt.done && ie_q && mask_q[rx_evt.ep] && !wr |=> irq)
    else $error("no irq");
  cov_setup_c: cover property (rx_evt.done && rx_evt.setup);
  cov_iso_c: cover property (rx_evt.done && v.etype == TYPE_ISO);
  cov_irq_c: cover property ($rose(irq));
endmodule : usbrx_chk
bind usbrx_ctrl usbrx_chk usbrx_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_evt(rx_evt), .bus_reset(bus_reset),
  .next_buf_busy(next_buf_busy), .ep_view(ep_view), .irq(irq));
`default_nettype wire

/* verification/usbrx_host.sv */
// Purpose: usb host side, hands clean out and setup completions to the block
// Assumes: completions arrive in the pclk domain
// Notes: gap lets a transaction come promptly or late
`timescale 1ns/100ps
`default_nettype none
module usbrx_host (
  input wire logic pclk,
  output usbrx_pkg::usbrx_evt_t rx_evt
);
  import usbrx_pkg::*;
  initial rx_evt = '0;
  // done is a single-cycle pulse, never held over
  task automatic xact(input logic [2:0] ep, input logic setup, input int gap);
    repeat (gap) @(posedge pclk);
    rx_evt <= '{done: 1'h1, setup: setup, ep: ep};
    @(posedge pclk);
    rx_evt <= '0;
    @(posedge pclk);
  endtask : xact
endmodule : usbrx_host
`default_nettype wire

/* verification/usbrx_ctrl_test.sv */
// Purpose: self-checking bench for the endpoint receive control block
// Assumes: zero-wait apb, bounded waits
// Notes: expected words built from the field layout
`timescale 1ns/100ps
`default_nettype none
module usbrx_ctrl_test;
  import usbrx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, bus_reset, next_buf_busy, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  usbrx_evt_t rx_evt;
  usbrx_ep_t [NUM_EP-1:0] ep_view;
  int n_fail, compares;
  usbrx_ctrl usbrx_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt),
    .bus_reset(bus_reset), .next_buf_busy(next_buf_busy), .ep_view(ep_view), .irq(irq));
  usbrx_host usbrx_host_i (.pclk(pclk), .rx_evt(rx_evt));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  // one apb transfer; a hung slave ends the run
  task automatic xf(input logic [7:0] a, input logic wn, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= wn;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      cmp(32'h0, 32'h1);
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xf
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xf(a, 1'h0, 32'h0);
    cmp(r, x);
  endtask : rd
  initial begin
    {presetn, psel, penable, pwrite, bus_reset, next_buf_busy} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < NUM_EP; i++) rd(ADDR_EP0 + 8'(4 * i), EP_RESET);
    rd(ADDR_CTRL, CTRL_RESET);
    xf(ADDR_CTRL, 1'h1, 32'h0000_8000);
    xf(ADDR_IRQ_MASK, 1'h1, 32'h0000_00FF);
    xf(8'h08, 1'h1, 32'h0000_8200);
    rd(8'h08, 32'h0000_0200);
    xf(8'h08, 1'h1, 32'h0000_C200);
    rd(8'h08, 32'h0000_4200);
    usbrx_host_i.xact(3'h2, 1'h1, 0);
    rd(8'h08, 32'h0000_AA00);
    cmp({31'h0, irq}, 32'h1);
    xf(8'h08, 1'h1, 32'h0000_0A00);
    rd(8'h08, 32'h0000_2A00);
    usbrx_host_i.xact(3'h2, 1'h0, 3);
    rd(8'h08, 32'h0000_E200);
    xf(8'h0C, 1'h1, 32'h0000_9400);
    rd(8'h0C, 32'h0000_1400);
    usbrx_host_i.xact(3'h3, 1'h0, 0);
    rd(8'h0C, 32'h0000_D400);
    xf(8'h14, 1'h1, 32'h0000_8600);
    rd(8'h14, 32'h0000_0600);
    xf(ADDR_IRQ_MASK, 1'h1, 32'h0);
    xf(ADDR_IRQ_STAT, 1'h1, 32'h0000_00FF);
    xf(8'h10, 1'h1, 32'h0000_8100);
    usbrx_host_i.xact(3'h4, 1'h0, 1);
    rd(8'h10, 32'h0000_C100);
    next_buf_busy <= 1'h1;
    usbrx_host_i.xact(3'h4, 1'h0, 0);
    next_buf_busy <= 1'h0;
    rd(8'h10, 32'h0000_A100);
    rd(ADDR_IRQ_STAT, 32'h0000_0010);
    cmp({31'h0, irq}, 32'h0);
    xf(8'h44, 1'h0, 32'h0);
    cmp({31'h0, e}, 32'h1);
    bus_reset <= 1'h1;
    @(posedge pclk);
    bus_reset <= 1'h0;
    rd(8'h08, 32'h0000_8000);
    xf(ADDR_CTRL, 1'h1, 32'h0000_8001);
    rd(8'h10, 32'h0000_8000);
    report_and_stop();
  end
endmodule : usbrx_ctrl_test
`default_nettype wire
